// >>> core/rbs_pkg.sv
/*
  Constants shared by the reset and brownout supervisor.
  Assumes a single 250 MHz core clock.
*/
package rbs_pkg;

  // Core clock period
  localparam int CLK_PERIOD_PS = 4000;

  // Fixed wake-up count of core clocks before release
  localparam int WAKE_CYC = 4096;
  localparam int WAKE_W = 13;

  // Oscillator must run continuously this long to count as stable
  localparam int OSC_STABLE_NS = 2000;
  localparam int OSC_CYC = (OSC_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OSC_W = 9;

  // Digital hysteresis: a brownout flag clears only after this quiet time
  localparam int BROWN_HYST_NS = 1000;
  localparam int BROWN_HYST_CYC = (BROWN_HYST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HYST_W = 8;

  // Processor fetch address after release
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

  // Reset cause bit positions
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_POR = 2;
  localparam int CAUSE_BROWN = 3;
  localparam int CAUSE_W = 4;
  localparam logic [3:0] CAUSE_RST = 4'h4;
  localparam logic [3:0] CAUSE_BROWN_ONLY = 4'h8;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_WAKE,
    ST_RUN
  } rbs_state_t;

endpackage : rbs_pkg

// >>> core/rbs_sync3.sv
/*
  Three-stage synchroniser for a level from outside the clock domain.
  The output follows once stages two and three agree.
  An optional asynchronous set forces the asserted value at once.
*/
module rbs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic aset_i,
  input wire logic d_i,
  output logic q_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Set acts without the clock, release passes all stages
  always_ff @(posedge clk_i or posedge aset_i) begin
    if (aset_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      q_o <= 1'b1;
    end else if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end

endmodule : rbs_sync3

// >>> core/rbs_hyst.sv
/*
  Hysteresis filter for a synchronised comparator flag.
  Sets on the first low-supply sample, clears after a quiet period.
  Input comes from logic on the same clock.
*/
module rbs_hyst (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic below_i,
  output logic flag_o
);
  import rbs_pkg::*;

  logic [HYST_W-1:0] quiet_q;

  // Slow release keeps a supply hovering at the threshold from chattering
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b1;
      quiet_q <= '0;
    end else if (below_i) begin
      flag_o <= 1'b1;
      quiet_q <= '0;
    end else if (flag_o) begin
      if (quiet_q == HYST_W'(BROWN_HYST_CYC - 1)) begin
        flag_o <= 1'b0;
        quiet_q <= '0;
      end else begin
        quiet_q <= quiet_q + HYST_W'(1);
      end
    end
  end

endmodule : rbs_hyst

// >>> core/rbs_supervisor.sv
/*
  Reset and brownout supervisor top.
  Merges reset sources, runs the wake-up sequence, drives the reset
  output pin and the brownout interrupt. Comparator and pin inputs are
  asynchronous; watchdog and flash-done come from the core clock domain.
*/
// What this block does
// RQ1 - Any of four sources asserts chip reset
// RQ2 - Usable supply: reset pin low, timer starts
// RQ3 - Release needs pin, oscillator, count, flash
// RQ4 - Pin high on release or brownout recovery
// RQ5 - Processor fetches from address zero
// RQ6 - Reset held long enough for register defaults
// RQ7 - Below upper threshold raises brownout interrupt
// RQ8 - Interrupt level also readable as status
// RQ9 - Below lower threshold forces chip reset
// RQ10 - Brownout reset held until power-on takes over
// RQ11 - Both thresholds filtered with hysteresis
// RQ12 - Code runs only after oscillator is stable
// RQ13 - Pin asserts at once, release synchronised
module rbs_supervisor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic wdt_reset_i,
  input wire logic por_i,
  input wire logic supply_ok_i,
  input wire logic brown_int_cmp_i,
  input wire logic brown_rst_cmp_i,
  input wire logic osc_run_i,
  input wire logic flash_init_done_i,
  output logic chip_reset_o,
  output logic reset_out_pin_o,
  output logic fetch_start_o,
  output logic [31:0] fetch_addr_o,
  output logic brownout_irq_o,
  output logic brownout_status_o,
  output logic [rbs_pkg::CAUSE_W-1:0] reset_cause_o
);
  import rbs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic ext_act;
  logic ext_assert;
  logic por_s;
  logic sup_s;
  logic int_s;
  logic rst_s;
  logic osc_s;
  logic brown_rst_f;

  assign ext_assert = ~ext_reset_n_i;

  rbs_sync3 #(.RST_VAL(1'b1)) u_sync_ext (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(ext_assert), // RQ13
    .d_i(1'b0),
    .q_o(ext_act)
  );

  rbs_sync3 #(.RST_VAL(1'b1)) u_sync_por (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(1'b0),
    .d_i(por_i),
    .q_o(por_s)
  );

  rbs_sync3 #(.RST_VAL(1'b0)) u_sync_sup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(1'b0),
    .d_i(supply_ok_i),
    .q_o(sup_s)
  );

  rbs_sync3 #(.RST_VAL(1'b1)) u_sync_int (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(1'b0),
    .d_i(brown_int_cmp_i),
    .q_o(int_s)
  );

  rbs_sync3 #(.RST_VAL(1'b1)) u_sync_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(1'b0),
    .d_i(brown_rst_cmp_i),
    .q_o(rst_s)
  );

  rbs_sync3 #(.RST_VAL(1'b0)) u_sync_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .aset_i(1'b0),
    .d_i(osc_run_i),
    .q_o(osc_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Brownout stages

  // Interrupt stage drives the controller line and the status bit
  rbs_hyst u_hyst_int ( // RQ11
    .clk_i(clk_i),
    .rst_i(rst_i),
    .below_i(int_s), // RQ7
    .flag_o(brownout_irq_o)
  );

  // Separate registered copy for the status register, clears one cycle after the interrupt; enable lives in the controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brownout_status_o <= 1'b1;
    end else begin
      brownout_status_o <= int_s | (brownout_irq_o & ~int_s); // RQ8
    end
  end

  rbs_hyst u_hyst_rst ( // RQ11
    .clk_i(clk_i),
    .rst_i(rst_i),
    .below_i(rst_s), // RQ9
    .flag_o(brown_rst_f)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reset request merge

  logic any_req;
  logic [CAUSE_W-1:0] cur_cause;

  always_comb begin
    cur_cause = '0;
    cur_cause[CAUSE_EXT] = ext_act;
    cur_cause[CAUSE_WDT] = wdt_reset_i;
    cur_cause[CAUSE_POR] = por_s;
    // Brownout flag stays up as the supply keeps falling; POR overlaps it
    cur_cause[CAUSE_BROWN] = brown_rst_f; // RQ10
  end

  assign any_req = |cur_cause; // RQ1

  ////////////////////////////////////////////////////////////////////////
  // Oscillator supervision

  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_ok;

  // A dropout of two or more samples restarts the stability window
  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_s) begin
      osc_cnt_q <= '0;
    end else if (osc_cnt_q != OSC_W'(OSC_CYC)) begin
      osc_cnt_q <= osc_cnt_q + OSC_W'(1); // RQ12
    end
  end

  assign osc_ok = (osc_cnt_q == OSC_W'(OSC_CYC));

  ////////////////////////////////////////////////////////////////////////
  // Wake-up sequence

  rbs_state_t state_q;
  rbs_state_t state_d;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic wake_done;

  assign wake_done = (wake_cnt_q == WAKE_W'(WAKE_CYC)) && osc_ok
                     && flash_init_done_i && !ext_act; // RQ3

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!any_req && sup_s) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (any_req || !sup_s) begin
          state_d = ST_HOLD;
        end else if (wake_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_req) begin
          state_d = ST_HOLD; // RQ1
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Timer restarts on every fresh assertion
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_WAKE) begin
      wake_cnt_q <= '0; // RQ2
    end else if (wake_cnt_q != WAKE_W'(WAKE_CYC)) begin
      wake_cnt_q <= wake_cnt_q + WAKE_W'(1);
    end
  end

  // The full count gives every block time to load its reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_reset_o <= 1'b1;
    end else begin
      chip_reset_o <= (state_d != ST_RUN); // RQ6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_start_o <= 1'b0;
      fetch_addr_o <= RESET_VECTOR;
    end else begin
      fetch_start_o <= (state_q == ST_WAKE) && (state_d == ST_RUN); // RQ5
      fetch_addr_o <= RESET_VECTOR; // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset cause and reset output pin

  // Causes accumulate over one reset episode, start fresh from run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_cause_o <= CAUSE_RST;
    end else if (any_req) begin
      reset_cause_o <= (state_q == ST_RUN ? '0 : reset_cause_o) | cur_cause;
    end
  end

  logic brown_recov;
  assign brown_recov = (reset_cause_o == CAUSE_BROWN_ONLY) && !any_req;

  // Pin is held low until the supply is usable
  always_ff @(posedge clk_i) begin
    if (rst_i || !sup_s) begin
      reset_out_pin_o <= 1'b0;
    end else if (any_req) begin
      reset_out_pin_o <= 1'b0; // RQ2
    end else begin
      reset_out_pin_o <= (state_d == ST_RUN) || brown_recov; // RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_any_source: assert property (any_req |=> chip_reset_o) // RQ1
    else $error("reset request did not hold chip reset");

  chk_pin_low: assert property (any_req && sup_s |=> !reset_out_pin_o) // RQ2
    else $error("reset pin high during a reset request");

  chk_release_ok: assert property ($fell(chip_reset_o) |->
    $past(flash_init_done_i) && !$past(ext_act) && $past(osc_ok)) // RQ3
    else $error("released without all start-up conditions");

  chk_wake_count: assert property ($fell(chip_reset_o) |->
    $past(wake_cnt_q) == WAKE_W'(WAKE_CYC)) // RQ6
    else $error("released before the wake count elapsed");

  chk_osc_window: assert property (!osc_s ##1 chip_reset_o |=> chip_reset_o) // RQ12
    else $error("released without a stable oscillator window");

  chk_pin_release: assert property ($fell(chip_reset_o) |->
    reset_out_pin_o && fetch_start_o && fetch_addr_o == RESET_VECTOR) // RQ4
    else $error("pin or fetch start missing at release");

  chk_fetch_once: assert property (fetch_start_o |=> !fetch_start_o) // RQ5
    else $error("fetch start longer than one cycle");

  chk_irq_follow: assert property (int_s |=> brownout_irq_o && brownout_status_o) // RQ7
    else $error("brownout interrupt not raised");

  chk_brown_hold: assert property (brown_rst_f |=> chip_reset_o [*2]) // RQ9
    else $error("brownout reset not held");

  chk_hyst_hold: assert property ($fell(int_s) |-> brownout_irq_o [*8]) // RQ11
    else $error("brownout flag chattered");

  chk_ext_assert: assert property ($rose(ext_act) |=> chip_reset_o) // RQ13
    else $error("external reset not applied");

  cov_release: cover property ($fell(chip_reset_o));
  cov_brown_recover: cover property (chip_reset_o && reset_out_pin_o);
  cov_irq: cover property ($rose(brownout_irq_o));

endmodule : rbs_supervisor

// >>> verif/rbs_supply_model.sv
/*
  Behavioural model of the far side: external reset pin and the
  regulator supply comparators, driven from a supply level in mV.
  Assumes the bench changes its inputs just after a clock edge.
*/
module rbs_supply_model #(
  parameter int BROWN_INT_MV = 2200,
  parameter int BROWN_RST_MV = 1850,
  parameter int POR_MV = 1000
) (
  input wire logic [15:0] supply_mv_i,
  input wire logic pin_low_i,
  input wire logic osc_en_i,
  output logic ext_reset_n_o,
  output logic por_o,
  output logic supply_ok_o,
  output logic brown_int_cmp_o,
  output logic brown_rst_cmp_o,
  output logic osc_run_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pin is a plain level; no clock on this side
  assign ext_reset_n_o = ~pin_low_i;
  // Below this level the power-on detector holds the reset instead
  assign por_o = (supply_mv_i < 16'(POR_MV));
  assign supply_ok_o = (supply_mv_i >= 16'(POR_MV));
  assign brown_int_cmp_o = (supply_mv_i < 16'(BROWN_INT_MV));
  assign brown_rst_cmp_o = (supply_mv_i < 16'(BROWN_RST_MV));
  // Oscillator needs supply as well as enable
  assign osc_run_o = osc_en_i & supply_ok_o;
endmodule : rbs_supply_model

// >>> verif/reset_brownout_supervisor_test.sv
/*
  Self-checking bench for the reset and brownout supervisor.
  Assumes the design package is compiled first; one 250 MHz clock.
*/
module reset_brownout_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rbs_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wdt_reset_i = 1'b0;
  logic flash_init_done_i = 1'b1;
  // Supply levels in mV: 3300, 2100, 1800, 1500, 900
  localparam logic [15:0] MV_NOM = 16'h0CE4;
  localparam logic [15:0] MV_UPPER = 16'h0834;
  localparam logic [15:0] MV_LOWER = 16'h0708;
  localparam logic [15:0] MV_DEEP = 16'h05DC;
  localparam logic [15:0] MV_POR = 16'h0384;
  // Ext and brownout stages start asserted after reset and join the cause
  localparam logic [3:0] PWR_CAUSE = CAUSE_RST | (4'h1 << CAUSE_EXT) | (4'h1 << CAUSE_BROWN);
  localparam logic [3:0] DIP_CAUSE = (4'h1 << CAUSE_POR) | (4'h1 << CAUSE_BROWN);
  logic [15:0] supply_mv = MV_NOM;
  logic pin_low = 1'b0;
  logic osc_en = 1'b0;
  logic ext_reset_n, por, supply_ok, brown_int_cmp, brown_rst_cmp, osc_run;
  logic chip_reset_o, reset_out_pin_o, fetch_start_o, brownout_irq_o, brownout_status_o;
  logic [31:0] fetch_addr_o;
  logic [3:0] reset_cause_o;
  int bad_count = 0;
  int cmp_count = 0;

  always #2 clk_i = ~clk_i;

  rbs_supply_model rbs_supply_model_inst (
    .supply_mv_i(supply_mv), .pin_low_i(pin_low), .osc_en_i(osc_en),
    .ext_reset_n_o(ext_reset_n), .por_o(por), .supply_ok_o(supply_ok),
    .brown_int_cmp_o(brown_int_cmp), .brown_rst_cmp_o(brown_rst_cmp), .osc_run_o(osc_run)
  );

  rbs_supervisor rbs_supervisor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n),
    .wdt_reset_i(wdt_reset_i), .por_i(por), .supply_ok_i(supply_ok),
    .brown_int_cmp_i(brown_int_cmp), .brown_rst_cmp_i(brown_rst_cmp), .osc_run_i(osc_run),
    .flash_init_done_i(flash_init_done_i), .chip_reset_o(chip_reset_o),
    .reset_out_pin_o(reset_out_pin_o), .fetch_start_o(fetch_start_o),
    .fetch_addr_o(fetch_addr_o), .brownout_irq_o(brownout_irq_o),
    .brownout_status_o(brownout_status_o), .reset_cause_o(reset_cause_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // Inputs always move one small delay after the rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask : step

  // Waits for the release pulse; returns the cycles spent
  task automatic wait_release(output int n);
    n = 0;
    while (fetch_start_o !== 1'b1 && n < 6000) begin
      step(1);
      n++;
    end
    check("release_seen", fetch_start_o, 1'b1);
    check("fetch_addr", fetch_addr_o, RESET_VECTOR);
    check("chip_reset_off", chip_reset_o, 1'b0);
    check("pin_high", reset_out_pin_o, 1'b1);
    step(1);
    check("release_pulse", fetch_start_o, 1'b0);
  endtask : wait_release

  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator off: the wake-up count alone must not release
  task automatic power_on_case();
    int n;
    step(5000);
    check("hold_no_osc", chip_reset_o, 1'b1);
    check("pin_low_no_osc", reset_out_pin_o, 1'b0);
    osc_en = 1'b1;
    wait_release(n);
    check("cause_por", reset_cause_o, PWR_CAUSE);
    check("irq_quiet", brownout_irq_o, 1'b0);
  endtask : power_on_case

  // One-cycle watchdog request, then timed wake-up
  task automatic watchdog_case();
    int n;
    wdt_reset_i = 1'b1;
    step(1);
    wdt_reset_i = 1'b0;
    check("wdt_reset", chip_reset_o, 1'b1);
    check("wdt_pin_low", reset_out_pin_o, 1'b0);
    check("wdt_cause", reset_cause_o, 4'h2);
    wait_release(n);
    check("wake_len", (n >= WAKE_CYC) && (n <= WAKE_CYC + 12), 1'b1);
  endtask : watchdog_case

  // Pin held long, then flash not ready after pin release
  task automatic ext_pin_case();
    int n;
    pin_low = 1'b1;
    step(2);
    check("ext_reset", chip_reset_o, 1'b1);
    step(5000);
    check("ext_hold", chip_reset_o, 1'b1);
    flash_init_done_i = 1'b0;
    pin_low = 1'b0;
    step(5000);
    check("flash_hold", chip_reset_o, 1'b1);
    check("ext_cause", reset_cause_o, 4'h1);
    flash_init_done_i = 1'b1;
    wait_release(n);
  endtask : ext_pin_case

  // Upper threshold: interrupt only, cleared after a quiet time
  task automatic brown_irq_case();
    supply_mv = MV_UPPER;
    step(8);
    check("brown_irq", brownout_irq_o, 1'b1);
    check("brown_status", brownout_status_o, 1'b1);
    check("brown_no_reset", chip_reset_o, 1'b0);
    supply_mv = MV_NOM;
    step(BROWN_HYST_CYC - 50);
    check("brown_hyst_hold", brownout_irq_o, 1'b1);
    step(60);
    check("brown_irq_clear", brownout_irq_o, 1'b0);
    check("brown_status_clear", brownout_status_o, 1'b0);
  endtask : brown_irq_case

  // Lower threshold, supply stays above power-on level: the pin returns
  // once the brownout flag clears, while the wake-up count still runs
  task automatic brown_reset_case();
    int n;
    supply_mv = MV_LOWER;
    step(8);
    check("brown_reset", chip_reset_o, 1'b1);
    check("brown_cause", reset_cause_o, CAUSE_BROWN_ONLY);
    supply_mv = MV_DEEP;
    step(2000);
    check("brown_hold", chip_reset_o, 1'b1);
    check("brown_pin_low", reset_out_pin_o, 1'b0);
    supply_mv = MV_NOM;
    n = 0;
    while (reset_out_pin_o !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
    check("brown_pin_high", reset_out_pin_o, 1'b1);
    check("brown_still_waking", chip_reset_o, 1'b1);
    wait_release(n);
  endtask : brown_reset_case

  // Dip under power-on level: power-on takes over, pin waits for release
  task automatic por_dip_case();
    int n;
    supply_mv = MV_LOWER;
    step(8);
    supply_mv = MV_POR;
    step(100);
    check("por_hold", chip_reset_o, 1'b1);
    check("por_cause", reset_cause_o, DIP_CAUSE);
    check("por_pin_low", reset_out_pin_o, 1'b0);
    supply_mv = MV_NOM;
    step(600);
    check("por_pin_waits", reset_out_pin_o, 1'b0);
    check("por_still_waking", chip_reset_o, 1'b1);
    wait_release(n);
  endtask : por_dip_case

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(16);
    rst_i = 1'b0;
    check("reset_held", chip_reset_o, 1'b1);
    power_on_case();
    watchdog_case();
    ext_pin_case();
    brown_irq_case();
    brown_reset_case();
    por_dip_case();
    final_report();
  end

  // Tests take about 31000 cycles; allow a wide margin
  initial begin
    #(60000 * 4);
    bad_count++;
    final_report();
  end
endmodule : reset_brownout_supervisor_test
